//--- common/audio_port_pkg.sv
// Purpose: shared constants and state layout of the audio serial port
// Assumes: 8-bit registers, each in the low byte of one aligned 32-bit APB word
// Notes:   word size field holds size minus one
package audio_port_pkg;

	// register byte addresses (index times four)
	localparam logic [7:0] OFS_CONFIG_A     = 8'h00;
	localparam logic [7:0] OFS_CONFIG_B     = 8'h04;
	localparam logic [7:0] OFS_LOW_BYTE     = 8'h08;
	localparam logic [7:0] OFS_HIGH_BYTE    = 8'h0c;
	localparam logic [7:0] OFS_WORD_TALLY   = 8'h10;
	localparam logic [7:0] OFS_STATUS       = 8'h14;
	localparam logic [7:0] OFS_DIV_FIRST    = 8'h18;
	localparam logic [7:0] OFS_DIV_SECOND   = 8'h1c;
	localparam logic [7:0] OFS_DIV_THIRD    = 8'h20;

	// config_reg_a fields
	localparam int unsigned A_TX_IRQ_ENABLE = 7;
	localparam int unsigned A_RX_IRQ_ENABLE = 6;
	localparam int unsigned A_EXPAND        = 5;
	localparam int unsigned A_COMPRESS      = 4;
	localparam int unsigned A_TX_SINGLE     = 3;
	localparam int unsigned A_RX_SINGLE     = 2;
	localparam int unsigned A_MASTER        = 1;
	localparam int unsigned A_ENABLE        = 0;

	// config_reg_b fields
	localparam int unsigned B_SIZE_LSB      = 0;
	localparam int unsigned B_TRIG_LSB      = 5;

	// port_status_reg fields
	localparam int unsigned S_RX_DONE       = 0;
	localparam int unsigned S_TX_DONE       = 1;
	localparam int unsigned S_RX_OVERRUN    = 2;
	localparam int unsigned S_TX_UNDERRUN   = 3;
	localparam int unsigned S_RX_SIDE       = 4;
	localparam int unsigned S_TX_SIDE       = 5;
	localparam int unsigned S_TALLY_LSB     = 6;
	localparam int unsigned D3_DIVIDER_DENOMINATOR_BIT    = 7;

	// reset values: 16-bit stereo, divider set for 44.1 kHz
	localparam logic [7:0] CONFIG_A_RST     = 8'h00;
	localparam logic [7:0] CONFIG_B_RST     = 8'h0f;
	localparam logic [7:0] DIV_FIRST_RST    = 8'h93;
	localparam logic [7:0] DIV_SECOND_RST   = 8'he2;
	localparam logic [7:0] DIV_THIRD_RST    = 8'h04;

	localparam logic [9:0]  TALLY_MAX       = 10'h3ff;
	localparam logic [15:0] ULAW_BIAS       = 16'h0084;
	localparam logic [15:0] ULAW_CLIP       = 16'h7f7b;

	typedef enum logic [1:0] {
		TRIG_SOFT  = 2'b00,
		TRIG_SOF   = 2'b01,
		TRIG_TIMER = 2'b10,
		TRIG_PIN   = 2'b11
	} trig_type;

	typedef struct packed {
		logic [7:0]  cfg_a;
		logic [7:0]  cfg_b;
		logic [7:0]  div_first;
		logic [7:0]  div_second;
		logic [7:0]  div_third;
		logic [7:0]  tx_low;
		logic [15:0] tx_buf;
		logic        tx_full;
		logic [15:0] tx_word;
		logic [15:0] tx_shift;
		logic        txd;
		logic        load_pend;
		logic        tx_side;
		logic [7:0]  data_hi;
		logic [7:0]  data_lo;
		logic        rx_full;
		logic [15:0] rx_shift;
		logic [5:0]  rx_cnt;
		logic        rx_side;
		logic        rx_done;
		logic        tx_done;
		logic        rx_ovf;
		logic        tx_unf;
		logic        sck_s1;
		logic        sck_s2;
		logic        sck_d;
		logic        ws_s1;
		logic        ws_s2;
		logic        rxd_s1;
		logic        rxd_s2;
		logic        sck_m;
		logic        ws_m;
		logic        ws_last;
		logic [15:0] acc;
		logic [4:0]  mbit;
		logic [9:0]  tally;
		logic [9:0]  tally_snap;
		logic        op_pend;
		logic        op_comp;
		logic [15:0] op_word;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        tx_dma;
		logic        rx_dma;
		logic        sck_oe;
		logic        ws_oe;
	} state_type;

endpackage : audio_port_pkg

//--- src/ulaw_codec.sv
// Purpose: combinational mu-law expander and compressor
// Assumes: 16-bit two's complement linear samples
// Notes:   both directions are independent and may be used in one cycle
`timescale 1ns/1ps
module ulaw_codec (
	// expansion
	input  wire logic [7:0]  code_in,
	output logic      [15:0] linear_out,
	// compression
	input  wire logic [15:0] linear_in,
	output logic      [7:0]  code_out
);

	always_comb begin
		logic [7:0]  c;
		logic [15:0] t;
		c = ~code_in;
		t = {9'h000, c[3:0], 3'b000};
		t = 16'((t + audio_port_pkg::ULAW_BIAS) << c[6:4]);
		linear_out = c[7] ? 16'(audio_port_pkg::ULAW_BIAS - t) : 16'(t - audio_port_pkg::ULAW_BIAS);
	end

	always_comb begin
		logic [15:0] mag;
		logic [2:0]  e;
		logic [15:0] m;
		mag = linear_in[15] ? 16'(~linear_in + 16'h0001) : linear_in;
		e = 3'h0;
		m = 16'h0000;
		// clip keeps the biased magnitude inside 15 bits
		if (mag > audio_port_pkg::ULAW_CLIP) begin
			mag = audio_port_pkg::ULAW_CLIP;
		end
		mag = 16'(mag + audio_port_pkg::ULAW_BIAS);
		for (int i = 0; i < 8; i++) begin
			if (mag[i + 7]) begin
				e = 3'(i);
			end
		end
		// shift worked out in four bits: segment seven would wrap in three
		m = mag >> (4'(e) + 4'h3);
		code_out = ~{linear_in[15], e, m[3:0]};
	end

endmodule : ulaw_codec

//--- src/audio_serial_port.sv
// Purpose: audio serial port with APB registers, master/slave link, word tally, mu-law
// Assumes: pclk is the system clock; triggers are single-cycle pulses on pclk
// Notes:   link pins are sampled through two flops; outputs come from flops
//
// Contract
// - low then high; high write completes sample
// - side flags show next tx and held rx
// - low then high; high read completes read
// - master bit drives clock and word select
// - clock is system clock over twice ratio
// - numerator and denominator split across dividers
// - master word size one to thirty-two
// - long words padded with trailing zeros
// - long received words keep top sixteen
// - slave follows external clock and select
// - slave resends last word after buffer empties
// - rx single channel ignores right words
// - tx single channel repeats word both sides
// - tally copied and cleared on trigger
// - trigger select chooses tally copy source
// - tally saturates instead of wrapping
// - enabled port expands tx, compresses rx
// - disabled port converts in one cycle
// - msb first, select low left, high right
// - rx done on copy, cleared by high read
// - underrun resends, overrun overwrites, software clears
`timescale 1ns/1ps
module audio_serial_port (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial link pins
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        ws_in,
	output logic             ws_out,
	output logic             ws_oe,
	input  wire logic        rx_data_in,
	output logic             tx_data_out,
	// tally triggers
	input  wire logic        sof_trigger,
	input  wire logic        timer_one_compare_zero,
	input  wire logic        pin_transition_trigger,
	// dma requests
	output logic             tx_dma_trigger,
	output logic             rx_dma_trigger
);

	audio_port_pkg::state_type st_r;
	audio_port_pkg::state_type st_nxt;

	logic [15:0] exp_out;
	logic [7:0]  cmp_out;
	logic [7:0]  exp_in;
	logic [15:0] cmp_in;
	logic [15:0] rx_mask;
	logic [15:0] rx_word_cur;
	logic        port_on;

	assign port_on = st_r.cfg_a[audio_port_pkg::A_ENABLE];
	// bits past the sixteenth fall off the mask and are dropped
	assign rx_mask = 16'h8000 >> st_r.rx_cnt;
	assign rx_word_cur = st_r.rxd_s2 ? (st_r.rx_shift | rx_mask) : st_r.rx_shift;
	assign exp_in = port_on ? pwdata[7:0] : st_r.op_word[7:0];
	assign cmp_in = port_on ? rx_word_cur : st_r.op_word;

	ulaw_codec codec (
		.code_in    (exp_in),
		.linear_out (exp_out),
		.linear_in  (cmp_in),
		.code_out   (cmp_out)
	);

	always_comb begin
		audio_port_pkg::state_type n;
		logic        setup;
		logic        done;
		logic        hit;
		logic [7:0]  rd;
		logic        master;
		logic        expand;
		logic        compress;
		logic [14:0] num;
		logic [8:0]  den;
		logic [16:0] acc_sum;
		logic        rise;
		logic        fall;
		logic        ws_now;
		logic        ws_edge;
		logic        tally_clr;
		audio_port_pkg::trig_type trig;
		n = st_r;
		setup = 1'b0;
		done = 1'b0;
		hit = 1'b1;
		rd = 8'h00;
		rise = 1'b0;
		fall = 1'b0;
		ws_edge = 1'b0;
		acc_sum = 17'h00000;
		ws_now = 1'b0;
		tally_clr = 1'b0;
		master = st_r.cfg_a[audio_port_pkg::A_MASTER];
		expand = st_r.cfg_a[audio_port_pkg::A_EXPAND];
		compress = st_r.cfg_a[audio_port_pkg::A_COMPRESS];
		num = {st_r.div_third[6:0], st_r.div_second};
		den = {st_r.div_third[audio_port_pkg::D3_DIVIDER_DENOMINATOR_BIT], st_r.div_first};
		trig = audio_port_pkg::trig_type'(st_r.cfg_b[audio_port_pkg::B_TRIG_LSB +: 2]);
		n.tx_dma = 1'b0;
		n.rx_dma = 1'b0;

		n.sck_s1 = sck_in;
		n.sck_s2 = st_r.sck_s1;
		n.sck_d  = st_r.sck_s2;
		n.ws_s1  = ws_in;
		n.ws_s2  = st_r.ws_s1;
		n.rxd_s1 = rx_data_in;
		n.rxd_s2 = st_r.rxd_s1;

		unique case (paddr)
			audio_port_pkg::OFS_CONFIG_A:   rd = st_r.cfg_a;
			audio_port_pkg::OFS_CONFIG_B:   rd = st_r.cfg_b;
			audio_port_pkg::OFS_LOW_BYTE:   rd = st_r.data_lo;
			audio_port_pkg::OFS_HIGH_BYTE:  rd = st_r.data_hi;
			audio_port_pkg::OFS_WORD_TALLY: rd = st_r.tally_snap[7:0];
			audio_port_pkg::OFS_STATUS: begin
				rd = {st_r.tally_snap[9:8], st_r.tx_side, st_r.rx_side,
					st_r.tx_unf, st_r.rx_ovf, st_r.tx_done, st_r.rx_done};
			end
			audio_port_pkg::OFS_DIV_FIRST:  rd = st_r.div_first;
			audio_port_pkg::OFS_DIV_SECOND: rd = st_r.div_second;
			audio_port_pkg::OFS_DIV_THIRD:  rd = st_r.div_third;
			default: hit = 1'b0;
		endcase

		// no wait state: answer is prepared in the setup cycle
		setup = psel & ~penable & ~st_r.pready;
		done = psel & penable & st_r.pready;
		n.pready = setup;
		// answer stands for the access cycle only
		n.pslverr = setup & ~hit;
		n.prdata = setup ? {24'h000000, rd} : 32'h00000000;

		if (st_r.op_pend) begin
			n.op_pend = 1'b0;
			if (st_r.op_comp) begin
				n.data_hi = cmp_out;
			end else begin
				n.data_hi = exp_out[15:8];
				n.data_lo = exp_out[7:0];
			end
		end

		if (done && !st_r.pslverr && pwrite) begin
			unique case (paddr)
				audio_port_pkg::OFS_CONFIG_A:   n.cfg_a = pwdata[7:0];
				audio_port_pkg::OFS_CONFIG_B:   n.cfg_b = pwdata[7:0];
				audio_port_pkg::OFS_LOW_BYTE:   n.tx_low = pwdata[7:0];
				audio_port_pkg::OFS_HIGH_BYTE: begin
					n.tx_done = 1'b0;
					if (!port_on && expand && !compress) begin
						n.op_pend = 1'b1;
						n.op_comp = 1'b0;
						n.op_word = {8'h00, pwdata[7:0]};
					end else if (!port_on && compress && !expand) begin
						n.op_pend = 1'b1;
						n.op_comp = 1'b1;
						n.op_word = {pwdata[7:0], st_r.tx_low};
					end else begin
						// a lone high write is a whole sample for short or coded data
						n.tx_buf = (port_on && expand) ? exp_out : {pwdata[7:0], st_r.tx_low};
						n.tx_full = 1'b1;
					end
				end
				audio_port_pkg::OFS_WORD_TALLY: ;
				audio_port_pkg::OFS_STATUS: begin
					n.rx_done = pwdata[audio_port_pkg::S_RX_DONE];
					n.tx_done = pwdata[audio_port_pkg::S_TX_DONE];
					n.rx_ovf = pwdata[audio_port_pkg::S_RX_OVERRUN];
					n.tx_unf = pwdata[audio_port_pkg::S_TX_UNDERRUN];
				end
				audio_port_pkg::OFS_DIV_FIRST:  n.div_first = pwdata[7:0];
				audio_port_pkg::OFS_DIV_SECOND: n.div_second = pwdata[7:0];
				audio_port_pkg::OFS_DIV_THIRD:  n.div_third = pwdata[7:0];
				default: ;
			endcase
		end
		if (done && !pwrite && paddr == audio_port_pkg::OFS_HIGH_BYTE) begin
			n.rx_done = 1'b0;
			n.rx_full = 1'b0;
		end

		ws_now = master ? st_r.ws_m : st_r.ws_s2;
		if (!port_on) begin
			n.acc = 16'h0000;
			n.sck_m = 1'b0;
			n.ws_m = 1'b0;
			n.mbit = 5'h00;
			n.load_pend = 1'b0;
			n.rx_cnt = 6'h00;
			n.rx_shift = 16'h0000;
			n.txd = 1'b0;
			n.ws_last = 1'b0;
		end else begin
			if (master) begin
				// fractional divider: toggle once per num/den system clocks
				acc_sum = 17'(st_r.acc) + 17'(den);
				if (acc_sum >= 17'(num)) begin
					n.acc = 16'(acc_sum - 17'(num));
					n.sck_m = ~st_r.sck_m;
					rise = ~st_r.sck_m;
					fall = st_r.sck_m;
				end else begin
					n.acc = acc_sum[15:0];
				end
			end else begin
				rise = st_r.sck_s2 & ~st_r.sck_d;
				fall = ~st_r.sck_s2 & st_r.sck_d;
			end

			if (rise) begin
				n.rx_shift = rx_word_cur;
				n.rx_cnt = (st_r.rx_cnt == 6'h3f) ? st_r.rx_cnt : 6'(st_r.rx_cnt + 6'h01);
				n.ws_last = ws_now;
				if (ws_now != st_r.ws_last) begin
					// select changed: this bit closed the word of the old side
					ws_edge = 1'b1;
					n.rx_shift = 16'h0000;
					n.rx_cnt = 6'h00;
					n.load_pend = 1'b1;
					if (!(st_r.cfg_a[audio_port_pkg::A_RX_SINGLE] && st_r.ws_last)) begin
						if (compress) begin
							n.data_hi = cmp_out;
							n.data_lo = 8'h00;
						end else begin
							n.data_hi = rx_word_cur[15:8];
							n.data_lo = rx_word_cur[7:0];
						end
						// a high read in this same cycle has already emptied it
						if (n.rx_full) begin
							n.rx_ovf = 1'b1;
						end
						n.rx_full = 1'b1;
						n.rx_done = 1'b1;
						n.rx_dma = 1'b1;
						n.rx_side = st_r.ws_last;
					end
				end
			end

			if (fall) begin
				n.tx_shift = {st_r.tx_shift[14:0], 1'b0};
				n.txd = st_r.tx_shift[15];
				if (st_r.load_pend) begin
					n.load_pend = 1'b0;
					if (!(st_r.cfg_a[audio_port_pkg::A_TX_SINGLE] && ws_now)) begin
						if (n.tx_full) begin
							n.tx_word = n.tx_buf;
							n.tx_full = 1'b0;
							n.tx_done = 1'b1;
							n.tx_dma = 1'b1;
							n.tx_side = st_r.cfg_a[audio_port_pkg::A_TX_SINGLE] ? 1'b0 : ~ws_now;
						end else begin
							n.tx_unf = 1'b1;
						end
					end
					n.txd = n.tx_word[15];
					n.tx_shift = {n.tx_word[14:0], 1'b0};
				end
				if (master) begin
					// select flips while the last bit of a word is on the line
					n.mbit = (st_r.mbit == st_r.cfg_b[4:0]) ? 5'h00 : 5'(st_r.mbit + 5'h01);
					if (n.mbit == st_r.cfg_b[4:0]) begin
						n.ws_m = ~st_r.ws_m;
					end
				end
			end
		end

		tally_clr = (done && pwrite && paddr == audio_port_pkg::OFS_WORD_TALLY);
		unique case (trig)
			audio_port_pkg::TRIG_SOFT:  ;
			audio_port_pkg::TRIG_SOF:   tally_clr = tally_clr | sof_trigger;
			audio_port_pkg::TRIG_TIMER: tally_clr = tally_clr | timer_one_compare_zero;
			audio_port_pkg::TRIG_PIN:   tally_clr = tally_clr | pin_transition_trigger;
		endcase
		if (ws_edge && st_r.tally != audio_port_pkg::TALLY_MAX) begin
			n.tally = 10'(st_r.tally + 10'h001);
		end
		if (tally_clr) begin
			n.tally_snap = st_r.tally;
			// a transition in the clearing cycle is kept as the first count
			n.tally = ws_edge ? 10'h001 : 10'h000;
		end

		n.sck_oe = n.cfg_a[audio_port_pkg::A_ENABLE] & n.cfg_a[audio_port_pkg::A_MASTER];
		n.ws_oe = n.sck_oe;
		st_nxt = n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.cfg_a <= audio_port_pkg::CONFIG_A_RST;
			st_r.cfg_b <= audio_port_pkg::CONFIG_B_RST;
			st_r.div_first <= audio_port_pkg::DIV_FIRST_RST;
			st_r.div_second <= audio_port_pkg::DIV_SECOND_RST;
			st_r.div_third <= audio_port_pkg::DIV_THIRD_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata         = st_r.prdata;
	assign pready         = st_r.pready;
	assign pslverr        = st_r.pslverr;
	assign sck_out        = st_r.sck_m;
	assign sck_oe         = st_r.sck_oe;
	assign ws_out         = st_r.ws_m;
	assign ws_oe          = st_r.ws_oe;
	assign tx_data_out    = st_r.txd;
	assign tx_dma_trigger = st_r.tx_dma;
	assign rx_dma_trigger = st_r.rx_dma;

endmodule : audio_serial_port

//--- verification/audio_port_monitor.sv
// Purpose: port-level checks of the audio serial port
// Assumes: divider ratio at least 3 while master
// Notes:   bound into every audio_serial_port
`timescale 1ns/1ps
module audio_port_monitor (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// link and dma
	input wire logic        sck_out,
	input wire logic        sck_oe,
	input wire logic        ws_out,
	input wire logic        ws_oe,
	input wire logic        tx_data_out,
	input wire logic        tx_dma_trigger,
	input wire logic        rx_dma_trigger
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_setup_answer: assert property (psel && !penable && !pready |=> pready)
		else $error("no answer after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	a_refuse_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("refusal without ready or with data");
	a_drive_pair: assert property (sck_oe == ws_oe)
		else $error("clock and select drive differ");
	a_sck_high_hold: assert property (sck_oe && $rose(sck_out)
		|=> (sck_out || !sck_oe) [*2]) else $error("serial clock high too short");
	a_ws_on_fall: assert property (sck_oe && $past(sck_oe) && $changed(ws_out)
		|-> $fell(sck_out)) else $error("select moved off a falling edge");
	a_txd_on_fall: assert property (sck_oe && $past(sck_oe) && $changed(tx_data_out)
		|-> $fell(sck_out)) else $error("data moved off a falling edge");
	a_tx_fetch_pulse: assert property (tx_dma_trigger |=> !tx_dma_trigger)
		else $error("tx request held");
	a_rx_copy_pulse: assert property (rx_dma_trigger |=> !rx_dma_trigger)
		else $error("rx request held");

	c_refused: cover property (pslverr);
	c_rx_copy: cover property (rx_dma_trigger);
	c_master_clock: cover property (sck_oe && $rose(sck_out));
endmodule : audio_port_monitor

bind audio_serial_port audio_port_monitor u_audio_port_monitor (.pclk, .presetn, .psel,
	.penable, .prdata, .pready, .pslverr, .sck_out, .sck_oe, .ws_out, .ws_oe, .tx_data_out,
	.tx_dma_trigger, .rx_dma_trigger);

//--- verification/codec_partner.sv
// Purpose: external codec model, clocks the link as master while run is high
// Assumes: 16-bit stereo words, serial half period of 8 pclk
// Notes:   captures what the port sends, whoever clocks the link
`timescale 1ns/1ps
module codec_partner (
	// clocking
	input  wire logic        clk,
	input  wire logic        run,
	// link
	input  wire logic        sck_line,
	input  wire logic        ws_line,
	output logic             sck_drv,
	output logic             ws_drv,
	output logic             sd_drv,
	input  wire logic        sd_in,
	// words
	input  wire logic [15:0] word_l,
	input  wire logic [15:0] word_r,
	output logic      [15:0] cap_l,
	output logic      [15:0] cap_r,
	output int               toggles
);
	logic [2:0]  div_cnt;
	logic [3:0]  bit_idx;
	logic        sck_q;
	logic        ws_q;
	logic [15:0] shift;
	logic [15:0] cur;

	initial begin
		{div_cnt, bit_idx, sck_q, ws_q, sck_drv, ws_drv, sd_drv} = '0;
		{shift, cap_l, cap_r} = '0;
		toggles = 0;
	end
	assign cur = ws_line ? word_r : word_l;

	always @(posedge clk) begin
		sck_q <= sck_line;
		// finish the high phase so the clock stands low between frames
		if (run || sck_drv) begin
			div_cnt <= div_cnt + 3'd1;
			if (div_cnt == 3'd7)
				sck_drv <= ~sck_drv;
		end
		if (sck_q && !sck_line) begin
			sd_drv <= cur[4'd15 - bit_idx];
			bit_idx <= bit_idx + 4'd1;
			if (bit_idx == 4'd15)
				ws_drv <= ~ws_drv;
		end else if (!run)
			sd_drv <= ~sd_drv;
		if (!sck_q && sck_line) begin
			shift <= {shift[14:0], sd_in};
			ws_q <= ws_line;
			// counted where a receiver sees it, at a serial rising edge
			if (ws_line != ws_q)
				toggles <= toggles + 1;
			if (ws_line != ws_q && ws_q)
				cap_r <= {shift[14:0], sd_in};
			else if (ws_line != ws_q)
				cap_l <= {shift[14:0], sd_in};
		end
	end
endmodule : codec_partner

//--- verification/tb.sv
// Purpose: directed bench for the audio serial port
// Assumes: codec model clocks all slave traffic
// Notes:   master checks use a 4 pclk serial half period
`timescale 1ns/1ps
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sck_out;
	logic        sck_oe;
	logic        ws_out;
	logic        ws_oe;
	logic        txd;
	logic        p_sck;
	logic        p_ws;
	logic        p_sd;
	logic        run = 1'b0;
	logic        side;
	logic        re;
	logic        txq;
	logic        rxq;
	int          n_rx = 0;
	int          n_tx = 0;
	logic [2:0]  trg = 3'h0;
	logic [15:0] cap_l;
	logic [15:0] cap_r;
	logic [15:0] w_l = 16'ha5c3;
	logic [15:0] w_r = 16'h5a3c;
	logic [31:0] rq;
	int          toggles;
	int          n0;
	int          n;
	int          n_fail = 0;
	int          num_checks = 0;
	logic [7:0]  cw [3] = '{8'h00, 8'h80, 8'hff};
	logic [15:0] lw [3] = '{16'h8284, 16'h7d7c, 16'h0000};
	wire         sck_line = sck_oe ? sck_out : p_sck;
	wire         ws_line = ws_oe ? ws_out : p_ws;

	always #2 pclk = ~pclk;

	// request pulses counted; unknown before reset counts as none
	always @(posedge pclk) begin
		if (rxq === 1'b1)
			n_rx <= n_rx + 1;
		if (txq === 1'b1)
			n_tx <= n_tx + 1;
	end

	audio_serial_port u_audio_serial_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sck_in(sck_line), .sck_out, .sck_oe,
		.ws_in(ws_line), .ws_out, .ws_oe, .rx_data_in(p_sd), .tx_data_out(txd),
		.sof_trigger(trg[0]), .timer_one_compare_zero(trg[1]),
		.pin_transition_trigger(trg[2]), .tx_dma_trigger(txq), .rx_dma_trigger(rxq));
	codec_partner u_codec_partner (.clk(pclk), .run, .sck_line, .ws_line, .sck_drv(p_sck),
		.ws_drv(p_ws), .sd_drv(p_sd), .sd_in(txd), .word_l(w_l), .word_r(w_r), .cap_l,
		.cap_r, .toggles);

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [31:0] e, input logic [31:0] g, input string what);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp

	// entered right after an edge; an idle cycle follows so strobes never bounce
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
		input string what);
		apb(a, 1'b0, 8'h00);
		cmp({24'h0, e}, rq & {24'h0, m}, what);
	endtask : rdc

	task automatic words(input int k);
		n0 = toggles;
		run <= 1'b1;
		repeat (k * 256) @(posedge pclk);
		run <= 1'b0;
		repeat (40) @(posedge pclk);
	endtask : words

	task automatic gap(input logic sel, output int cnt);
		logic v;
		cnt = 0;
		v = sel ? ws_out : sck_out;
		while ((sel ? ws_out : sck_out) === v) @(posedge pclk);
		v = ~v;
		while ((sel ? ws_out : sck_out) === v) begin
			cnt++;
			@(posedge pclk);
		end
	endtask : gap

	initial begin
		#200000;
		n_fail++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(audio_port_pkg::OFS_CONFIG_A, 8'hff, audio_port_pkg::CONFIG_A_RST, "cfg a");
		rdc(audio_port_pkg::OFS_CONFIG_B, 8'hff, audio_port_pkg::CONFIG_B_RST, "cfg b");
		rdc(audio_port_pkg::OFS_DIV_FIRST, 8'hff, audio_port_pkg::DIV_FIRST_RST, "div 1");
		rdc(audio_port_pkg::OFS_DIV_SECOND, 8'hff, audio_port_pkg::DIV_SECOND_RST, "div 2");
		rdc(audio_port_pkg::OFS_DIV_THIRD, 8'hff, audio_port_pkg::DIV_THIRD_RST, "div 3");
		apb(8'h24, 1'b0, 8'h00);
		cmp(32'h1, {31'h0, re}, "unmapped refusal");
		wr(8'h02, 8'h55);
		cmp(32'h1, {31'h0, re}, "unaligned refusal");
		for (int i = 0; i < 3; i++) begin
			wr(audio_port_pkg::OFS_CONFIG_A, 8'h20);
			wr(audio_port_pkg::OFS_HIGH_BYTE, cw[i]);
			repeat (2) @(posedge pclk);
			rdc(audio_port_pkg::OFS_LOW_BYTE, 8'hff, lw[i][7:0], "expand lo");
			rdc(audio_port_pkg::OFS_HIGH_BYTE, 8'hff, lw[i][15:8], "expand hi");
			wr(audio_port_pkg::OFS_CONFIG_A, 8'h10);
			wr(audio_port_pkg::OFS_LOW_BYTE, lw[i][7:0]);
			wr(audio_port_pkg::OFS_HIGH_BYTE, lw[i][15:8]);
			repeat (2) @(posedge pclk);
			rdc(audio_port_pkg::OFS_HIGH_BYTE, 8'hff, cw[i], "compress");
		end
		wr(audio_port_pkg::OFS_CONFIG_A, 8'h00);
		wr(audio_port_pkg::OFS_LOW_BYTE, 8'h3c);
		wr(audio_port_pkg::OFS_HIGH_BYTE, 8'h96);
		wr(audio_port_pkg::OFS_CONFIG_A, 8'h09);
		words(6);
		cmp(32'h963c963c, {cap_l, cap_r}, "sent words");
		cmp(toggles - n0, n_rx, "rx copies");
		cmp(32'h1, n_tx, "tx fetches");
		apb(audio_port_pkg::OFS_STATUS, 1'b0, 8'h00);
		cmp(32'hf, rq & 32'hf, "status flags");
		side = rq[audio_port_pkg::S_RX_SIDE];
		rdc(audio_port_pkg::OFS_LOW_BYTE, 8'hff, side ? w_r[7:0] : w_l[7:0], "rx lo");
		rdc(audio_port_pkg::OFS_HIGH_BYTE, 8'hff, side ? w_r[15:8] : w_l[15:8], "rx hi");
		rdc(audio_port_pkg::OFS_STATUS, 8'h01, 8'h00, "rx done");
		wr(audio_port_pkg::OFS_HIGH_BYTE, 8'h96);
		rdc(audio_port_pkg::OFS_STATUS, 8'h02, 8'h00, "tx done");
		wr(audio_port_pkg::OFS_STATUS, 8'h00);
		rdc(audio_port_pkg::OFS_STATUS, 8'h0c, 8'h00, "error flags");
		wr(audio_port_pkg::OFS_WORD_TALLY, 8'h00);
		rdc(audio_port_pkg::OFS_WORD_TALLY, 8'hff, 8'(toggles - n0), "sw tally");
		wr(audio_port_pkg::OFS_CONFIG_A, 8'h15);
		words(4);
		// 8'h09 codes the left word; the right word would code as 8'h89
		rdc(audio_port_pkg::OFS_LOW_BYTE, 8'hff, 8'h00, "mono lo");
		rdc(audio_port_pkg::OFS_HIGH_BYTE, 8'hff, 8'h09, "mono hi");
		wr(audio_port_pkg::OFS_WORD_TALLY, 8'h00);
		for (int k = 1; k < 4; k++) begin
			wr(audio_port_pkg::OFS_CONFIG_B, {1'b0, 2'(k), 5'h0f});
			words(k + 1);
			// a foreign trigger first: it must not clear the count
			trg <= 3'(1 << (k % 3));
			@(posedge pclk);
			trg <= 3'(1 << (k - 1));
			@(posedge pclk);
			trg <= 3'h0;
			repeat (2) @(posedge pclk);
			rdc(audio_port_pkg::OFS_WORD_TALLY, 8'hff, 8'(toggles - n0), "trig tally");
		end
		wr(audio_port_pkg::OFS_CONFIG_A, 8'h00);
		wr(audio_port_pkg::OFS_DIV_FIRST, 8'h00);
		wr(audio_port_pkg::OFS_DIV_SECOND, 8'h00);
		wr(audio_port_pkg::OFS_DIV_THIRD, 8'h84);
		wr(audio_port_pkg::OFS_CONFIG_B, 8'h07);
		wr(audio_port_pkg::OFS_CONFIG_A, 8'h03);
		repeat (2) @(posedge pclk);
		cmp(32'h3, {30'h0, sck_oe, ws_oe}, "master drive");
		gap(1'b0, n);
		cmp(32'd4, n, "sck half period");
		gap(1'b1, n);
		cmp(32'd64, n, "ws half period");
		complete_run();
	end
endmodule : tb
